// file: rtl/tmr_pkg.sv
`default_nettype none

package tmr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and counter-domain tick
	localparam int unsigned         CLK_HZ      = 10_000_000;
	localparam logic [3:0]          TICK_DIV    = 4'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [7:0]          IDX_CTRL    = 8'h00;
	localparam logic [7:0]          IDX_IEC     = 8'h0c;
	localparam logic [7:0]          IDX_IES     = 8'h0d;
	localparam logic [7:0]          IDX_FLG     = 8'h0e;
	localparam logic [7:0]          IDX_STS     = 8'h0f;
	localparam logic [7:0]          IDX_CNT     = 8'h10;
	localparam logic [7:0]          IDX_PER     = 8'h14;
	localparam logic [7:0]          IDX_CC0     = 8'h18;
	localparam logic [7:0]          IDX_CC1     = 8'h19;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt enable / flag layout
	localparam int unsigned         BIT_OVF     = 0;
	localparam int unsigned         BIT_ERR     = 1;
	localparam int unsigned         BIT_SYNC    = 3;
	localparam int unsigned         BIT_MC0     = 4;
	localparam logic [7:0]          IRQ_MASK    = 8'h3b;

	// Status layout
	localparam int unsigned         STS_BUSY    = 7;
	localparam int unsigned         STS_SLAVE   = 4;
	localparam int unsigned         STS_STOP    = 3;
	localparam logic [7:0]          STS_RESET   = 8'h08;

	// Control layout
	localparam int unsigned         CTL_EN      = 0;
	localparam int unsigned         CTL_WIDE    = 1;
	localparam int unsigned         CTL_SINGLE_RUN_OPTION = 2;
	localparam int unsigned         CTL_CPT0    = 4;
	localparam int unsigned         CTL_STOP    = 6;
	localparam int unsigned         CTL_RETRIG  = 7;

	localparam logic [15:0]         PER_RESET   = 16'hffff;
	localparam logic [1:0]          RESP_OKAY   = 2'h0;
	localparam logic [1:0]          RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Bus carriers
	typedef struct packed {
		logic                       awvalid;
		logic [9:0]                 awaddr;
		logic                       wvalid;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bready;
		logic                       arvalid;
		logic [9:0]                 araddr;
		logic                       rready;
	} tmr_axi_req_t;

	typedef struct packed {
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} tmr_axi_rsp_t;

	typedef enum logic [0:0] {
		TMR_RUN  = 1'b0,
		TMR_HALT = 1'b1
	} tmr_run_t;

	typedef struct packed {
		tmr_axi_rsp_t               rsp;
		logic                       aw_have;
		logic [9:0]                 aw_addr;
		logic                       w_have;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic [7:0]                 ctrl;
		logic [7:0]                 ien;
		logic [7:0]                 flags;
		tmr_run_t                   run;
		logic                       slave;
		logic [3:0]                 div;
		logic [15:0]                count;
		logic [15:0]                per;
		logic [1:0][15:0]           cc;
		logic                       sync_pend;
		logic [15:0]                cnt_wval;
		logic                       ovf_pend;
		logic                       err_pend;
		logic [1:0]                 mc_pend;
		logic [1:0]                 cap_req;
		logic                       irq;
	} tmr_state_t;

endpackage : tmr_pkg

`default_nettype wire

// file: rtl/tmr_regs.sv
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tmr_regs #(
	parameter logic                 IS_SLAVE = 1'b0
) (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire tmr_pkg::tmr_axi_req_t axi_req_i,
	output var  tmr_pkg::tmr_axi_rsp_t axi_rsp_o,
	input  wire logic               guard_lock_i,
	input  wire logic               master_wide_i,
	input  wire logic [1:0]         capture_event_i,
	output logic                    irq_o,
	output logic [15:0]             count_o,
	output logic                    stopped_o
);

	tmr_pkg::tmr_state_t            s_q;
	tmr_pkg::tmr_state_t            s_d;

	function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
		hit = (addr[9:2] == idx);
	endfunction : hit

	function automatic logic mapped(input logic [9:0] addr);
		mapped = hit(addr, tmr_pkg::IDX_CTRL) || hit(addr, tmr_pkg::IDX_IEC)
			|| hit(addr, tmr_pkg::IDX_IES) || hit(addr, tmr_pkg::IDX_FLG)
			|| hit(addr, tmr_pkg::IDX_STS) || hit(addr, tmr_pkg::IDX_CNT)
			|| hit(addr, tmr_pkg::IDX_PER) || hit(addr, tmr_pkg::IDX_CC0)
			|| hit(addr, tmr_pkg::IDX_CC1);
	endfunction : mapped

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic        wr_fire;
		logic        tick;
		logic        wide;
		logic [15:0] mask;
		logic [15:0] top;
		logic [7:0]  flg_clr;
		logic [7:0]  flg_set;
		logic [7:0]  wb;
		logic [7:0]  rb;
		logic [31:0] rd;
		wr_fire = 1'b0;
		tick    = 1'b0;
		wide    = 1'b0;
		mask    = 16'h0000;
		top     = 16'h0000;
		flg_clr = 8'h00;
		flg_set = 8'h00;
		wb      = 8'h00;
		rb      = 8'h00;
		rd      = 32'h0000_0000;
		s_d     = s_q;

		wide = s_q.ctrl[tmr_pkg::CTL_WIDE];
		mask = wide ? 16'hffff : 16'h00ff;
		top  = s_q.per & mask;

		// Counter-domain tick from the divider
		tick = (s_q.div == (tmr_pkg::TICK_DIV - 4'h1));
		s_d.div = tick ? 4'h0 : s_q.div + 4'h1;

		// Capture requests wait for the next tick
		s_d.cap_req = s_q.cap_req | (capture_event_i & s_q.ctrl[tmr_pkg::CTL_CPT0 +: 2]);

		//////////////////////////////////////////////////////////////////////////
		// Write channel
		if (axi_req_i.awvalid && s_q.rsp.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid && s_q.rsp.wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = axi_req_i.wdata;
			s_d.w_strb = axi_req_i.wstrb;
		end
		if (s_q.rsp.bvalid && axi_req_i.bready) begin
			s_d.rsp.bvalid = 1'b0;
		end
		wr_fire = s_d.aw_have && s_d.w_have && !s_d.rsp.bvalid;
		wb = s_d.w_strb[0] ? s_d.w_data[7:0] : 8'h00;

		if (wr_fire) begin
			s_d.aw_have    = 1'b0;
			s_d.w_have     = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp  = mapped(s_d.aw_addr) ? tmr_pkg::RESP_OKAY
				: tmr_pkg::RESP_SLVERR;
			// Guarded registers ignore writes while locked
			if (!guard_lock_i) begin
				if (hit(s_d.aw_addr, tmr_pkg::IDX_IEC)) begin
					s_d.ien = s_q.ien & ~(wb & tmr_pkg::IRQ_MASK);
				end
				if (hit(s_d.aw_addr, tmr_pkg::IDX_IES)) begin
					s_d.ien = s_q.ien | (wb & tmr_pkg::IRQ_MASK);
				end
				if (hit(s_d.aw_addr, tmr_pkg::IDX_CTRL) && s_d.w_strb[0]) begin
					s_d.ctrl = {2'b00, wb[5:0]};
					if (!wb[tmr_pkg::CTL_EN] || wb[tmr_pkg::CTL_STOP]) begin
						s_d.run = tmr_pkg::TMR_HALT;
					end else if (!s_q.ctrl[tmr_pkg::CTL_EN] || wb[tmr_pkg::CTL_RETRIG]) begin
						s_d.run   = tmr_pkg::TMR_RUN;
						s_d.count = wb[tmr_pkg::CTL_RETRIG] ? 16'h0000 : s_q.count;
					end
				end
				if (hit(s_d.aw_addr, tmr_pkg::IDX_CNT)) begin
					// Count write crosses to the counter domain at the next tick
					s_d.sync_pend = 1'b1;
					s_d.cnt_wval  = {s_d.w_strb[1] ? s_d.w_data[15:8] : s_q.count[15:8],
						s_d.w_strb[0] ? s_d.w_data[7:0] : s_q.count[7:0]};
				end
			end
			if (hit(s_d.aw_addr, tmr_pkg::IDX_FLG)) begin
				flg_clr = wb & tmr_pkg::IRQ_MASK;
			end
			if (hit(s_d.aw_addr, tmr_pkg::IDX_PER)) begin
				if (s_d.w_strb[0]) s_d.per[7:0] = s_d.w_data[7:0];
				if (s_d.w_strb[1]) s_d.per[15:8] = s_d.w_data[15:8];
			end
			for (int i = 0; i < 2; i++) begin
				if (hit(s_d.aw_addr, tmr_pkg::IDX_CC0 + 8'(i))) begin
					if (s_d.w_strb[0]) s_d.cc[i][7:0] = s_d.w_data[7:0];
					if (s_d.w_strb[1]) s_d.cc[i][15:8] = s_d.w_data[15:8];
				end
			end
		end
		s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
		s_d.rsp.wready  = !s_d.w_have && !s_d.rsp.bvalid;

		//////////////////////////////////////////////////////////////////////////
		// Read channel
		if (s_q.rsp.rvalid && axi_req_i.rready) begin
			s_d.rsp.rvalid = 1'b0;
		end
		if (axi_req_i.arvalid && s_q.rsp.arready) begin
			rb = 8'h00;
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_CTRL)) rb = s_q.ctrl;
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_IEC)) rb = s_q.ien;
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_IES)) rb = s_q.ien;
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_FLG)) rb = s_q.flags;
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_STS)) begin
				rb[tmr_pkg::STS_BUSY]  = s_q.sync_pend;
				rb[tmr_pkg::STS_SLAVE] = s_q.slave;
				rb[tmr_pkg::STS_STOP]  = (s_q.run == tmr_pkg::TMR_HALT);
			end
			rd = {24'h00_0000, rb};
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_CNT)) rd = {16'h0000, s_q.count & mask};
			if (hit(axi_req_i.araddr, tmr_pkg::IDX_PER)) rd = {16'h0000, s_q.per & mask};
			for (int i = 0; i < 2; i++) begin
				if (hit(axi_req_i.araddr, tmr_pkg::IDX_CC0 + 8'(i))) begin
					rd = {16'h0000, s_q.cc[i] & mask};
					// Reading a captured value frees its slot
					if (s_q.ctrl[tmr_pkg::CTL_CPT0 + i]) begin
						flg_clr[tmr_pkg::BIT_MC0 + i] = 1'b1;
					end
				end
			end
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata  = rd;
			s_d.rsp.rresp  = mapped(axi_req_i.araddr) ? tmr_pkg::RESP_OKAY
				: tmr_pkg::RESP_SLVERR;
		end
		s_d.rsp.arready = !s_d.rsp.rvalid;

		//////////////////////////////////////////////////////////////////////////
		// Counter domain, advanced once per tick
		if (tick) begin
			// Events seen on the previous tick land as flags now
			flg_set[tmr_pkg::BIT_OVF] = s_q.ovf_pend;
			flg_set[tmr_pkg::BIT_ERR] = s_q.err_pend;
			flg_set[tmr_pkg::BIT_MC0 +: 2] = s_q.mc_pend;
			s_d.ovf_pend = 1'b0;
			s_d.err_pend = 1'b0;
			s_d.mc_pend  = 2'b00;

			if (s_q.sync_pend) begin
				s_d.count     = s_q.cnt_wval & mask;
				s_d.sync_pend = 1'b0;
				flg_set[tmr_pkg::BIT_SYNC] = 1'b1;
			end else if (s_q.run == tmr_pkg::TMR_RUN) begin
				if ((s_q.count & mask) == top) begin
					s_d.count    = 16'h0000;
					s_d.ovf_pend = 1'b1;
					if (s_q.ctrl[tmr_pkg::CTL_SINGLE_RUN_OPTION]) begin
						s_d.run = tmr_pkg::TMR_HALT;
					end
				end else begin
					s_d.count = (s_q.count + 16'h0001) & mask;
				end
			end

			for (int i = 0; i < 2; i++) begin
				if (s_q.ctrl[tmr_pkg::CTL_CPT0 + i]) begin
					if (s_q.cap_req[i]) begin
						// No room for a second capture while the flag stands
						if (s_q.flags[tmr_pkg::BIT_MC0 + i]) begin
							s_d.err_pend = 1'b1;
						end else begin
							s_d.cc[i]      = s_q.count & mask;
							s_d.mc_pend[i] = 1'b1;
						end
					end
				end else if (s_q.run == tmr_pkg::TMR_RUN
					&& (s_q.count & mask) == (s_q.cc[i] & mask)) begin
					s_d.mc_pend[i] = 1'b1;
				end
			end
			s_d.cap_req = capture_event_i & s_q.ctrl[tmr_pkg::CTL_CPT0 +: 2];
		end

		// Hardware set wins over software clear
		s_d.flags = ((s_q.flags & ~flg_clr) | flg_set) & tmr_pkg::IRQ_MASK;
		s_d.slave = IS_SLAVE & master_wide_i;
		s_d.irq   = |(s_d.flags & s_d.ien);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q       <= '0;
			s_q.run   <= tmr_pkg::TMR_HALT;
			s_q.per   <= tmr_pkg::PER_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign axi_rsp_o = s_q.rsp;
	assign irq_o     = s_q.irq;
	assign count_o   = s_q.count;
	assign stopped_o = (s_q.run == tmr_pkg::TMR_HALT);

endmodule : tmr_regs

`default_nettype wire

// file: test/tmr_regs_assertions.sv
`default_nettype none
module tmr_chk (
	input wire logic                  clk_i,
	input wire logic                  reset_n_i,
	input wire tmr_pkg::tmr_axi_req_t axi_req_i,
	input wire tmr_pkg::tmr_axi_rsp_t axi_rsp_o,
	input wire logic                  irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_r_hold;
		axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_b_hold;
		axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_ar_ref;
		axi_rsp_o.rvalid |-> !axi_rsp_o.arready;
	endproperty
	a_ar_ref: assert property (p_ar_ref) else $error("read taken while answer pending");
	property p_aw_ref;
		axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
	endproperty
	a_aw_ref: assert property (p_aw_ref) else $error("write taken while answer pending");
	property p_r_ans;
		axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("read answer late");
	property p_b_ans;
		axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready
			|=> axi_rsp_o.bvalid;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("write answer late");
	// Ready comes back in the very cycle after the answer is taken
	property p_r_done;
		axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid && axi_rsp_o.arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read not released");
	property p_w_done;
		axi_rsp_o.bvalid && axi_req_i.bready
			|=> !axi_rsp_o.bvalid && axi_rsp_o.awready && axi_rsp_o.wready;
	endproperty
	a_w_done: assert property (p_w_done) else $error("write not released");
	property p_irq_rst;
		$rose(reset_n_i) |-> !irq_o;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
endmodule : tmr_chk
`default_nettype wire

// file: test/tmr_regs_bench.sv
`default_nettype none
module tmr_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk_i     = 1'b0;
	logic                  reset_n_i = 1'b0;
	tmr_pkg::tmr_axi_req_t req       = '0;
	tmr_pkg::tmr_axi_rsp_t rsp;
	logic                  lock      = 1'b0;
	logic                  wide      = 1'b0;
	logic [1:0]            cap       = 2'h0;
	logic                  irq;
	logic [15:0]           cnt;
	logic                  stp;
	int                    bad_count  = 0;
	int                    num_checks = 0;
	logic [31:0]           d;
	logic [1:0]            r;
	logic [7:0]            e, x, y;
	int                    n;
	always #50 clk_i = ~clk_i;
	// Slave build so the chained-pair status bit can be seen
	tmr_regs #(.IS_SLAVE(1'b1)) u_tmr_regs (
		.clk_i          (clk_i),
		.reset_n_i      (reset_n_i),
		.axi_req_i      (req),
		.axi_rsp_o      (rsp),
		.guard_lock_i   (lock),
		.master_wide_i  (wide),
		.capture_event_i(cap),
		.irq_o          (irq),
		.count_o        (cnt),
		.stopped_o      (stp)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] g, input logic [31:0] v);
		num_checks++;
		if (g !== v) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, g, v);
		end
	endtask : chk
	task automatic hang(input int k);
		if (k >= 50) begin
			bad_count++;
			end_of_test();
		end
	endtask : hang
	// Each channel released on its own ready; start one edge later so bready is never re-driven
	task automatic wr(input logic [7:0] i, input logic [31:0] v);
		int k;
		@(posedge clk_i);
		req.awaddr <= {i, 2'b00};
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			k++;
		end while (!rsp.bvalid && k < 50);
		chk({30'h0, rsp.bresp}, {30'h0, tmr_pkg::RESP_OKAY});
		req.bready <= 1'b0;
		hang(k);
	endtask : wr
	task automatic rd(input logic [7:0] i, output logic [31:0] v, output logic [1:0] s);
		int k;
		@(posedge clk_i);
		req.araddr <= {i, 2'b00};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			if (rsp.arready) req.arvalid <= 1'b0;
			k++;
		end while (!rsp.rvalid && k < 50);
		v = rsp.rdata;
		s = rsp.rresp;
		req.rready <= 1'b0;
		hang(k);
	endtask : rd
	task automatic rc(input logic [7:0] i, input logic [15:0] m, input logic [15:0] v);
		logic [31:0] g;
		logic [1:0]  s;
		rd(i, g, s);
		chk({16'h0, g[15:0] & m}, {16'h0, v});
	endtask : rc
	function automatic logic [7:0] en_f(logic [7:0] o, logic [7:0] s, logic [7:0] c);
		return ((o | s) & ~c) & tmr_pkg::IRQ_MASK;
	endfunction : en_f
	task automatic pulse;
		@(posedge clk_i);
		cap <= 2'h1;
		@(posedge clk_i);
		cap <= 2'h0;
		repeat (12) @(posedge clk_i);
	endtask : pulse
	task automatic wait_stp(input logic v);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (stp !== v && n < 200);
		hang(n / 4);
	endtask : wait_stp
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(81));
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rc(tmr_pkg::IDX_IEC, 16'hff, 16'h0);
		rc(tmr_pkg::IDX_FLG, 16'hff, 16'h0);
		rc(tmr_pkg::IDX_STS, 16'hff, 16'h8);
		rc(tmr_pkg::IDX_CNT, 16'hffff, 16'h0);
		e = 8'h0;
		for (int k = 0; k < 4; k++) begin
			x = 8'($urandom);
			y = 8'($urandom);
			wr(tmr_pkg::IDX_IES, {24'h0, x});
			e = en_f(e, x, 8'h0);
			rc(tmr_pkg::IDX_IEC, 16'hff, {8'h0, e});
			wr(tmr_pkg::IDX_IEC, {24'h0, y});
			e = en_f(e, 8'h0, y);
			rc(tmr_pkg::IDX_IES, 16'hff, {8'h0, e});
		end
		wr(tmr_pkg::IDX_IEC, 32'hff);
		lock <= 1'b1;
		wr(tmr_pkg::IDX_IES, 32'hff);
		rc(tmr_pkg::IDX_IES, 16'hff, 16'h0);
		lock <= 1'b0;
		wide <= 1'b1;
		rc(tmr_pkg::IDX_STS, 16'h10, 16'h10);
		wide <= 1'b0;
		wr(tmr_pkg::IDX_CNT, 32'h1234);
		repeat (12) @(posedge clk_i);
		rc(tmr_pkg::IDX_CNT, 16'hffff, 16'h34);
		rc(tmr_pkg::IDX_FLG, 16'h08, 16'h08);
		rc(tmr_pkg::IDX_STS, 16'h80, 16'h0);
		// Capture on ch0; ch1 compare and wrap may also fire, so mask them out
		wr(tmr_pkg::IDX_CTRL, 32'h11);
		pulse();
		rc(tmr_pkg::IDX_FLG, 16'h12, 16'h10);
		chk({31'h0, irq}, 0);
		pulse();
		rc(tmr_pkg::IDX_FLG, 16'h12, 16'h12);
		wr(tmr_pkg::IDX_FLG, 32'h0);
		rc(tmr_pkg::IDX_FLG, 16'h12, 16'h12);
		wr(tmr_pkg::IDX_IES, 32'h10);
		rc(tmr_pkg::IDX_IES, 16'hff, 16'h10);
		chk({31'h0, irq}, 1);
		rd(tmr_pkg::IDX_CC0, d, r);
		rc(tmr_pkg::IDX_FLG, 16'h10, 16'h0);
		wr(tmr_pkg::IDX_FLG, 32'h02);
		rc(tmr_pkg::IDX_FLG, 16'h02, 16'h0);
		wr(tmr_pkg::IDX_IEC, 32'hff);
		wr(tmr_pkg::IDX_CTRL, 32'h0);
		rc(tmr_pkg::IDX_STS, 16'h08, 16'h08);
		wr(tmr_pkg::IDX_PER, 32'h3);
		wr(tmr_pkg::IDX_FLG, 32'hff);
		wr(tmr_pkg::IDX_IES, 32'h01);
		wr(tmr_pkg::IDX_CTRL, 32'h85);
		wait_stp(1'b0);
		wait_stp(1'b1);
		chk({31'h0, stp}, 1);
		repeat (8) @(posedge clk_i);
		chk({16'h0, cnt}, 0);
		rc(tmr_pkg::IDX_FLG, 16'h01, 16'h01);
		chk({31'h0, irq}, 1);
		wr(tmr_pkg::IDX_FLG, 32'h0);
		rc(tmr_pkg::IDX_FLG, 16'h01, 16'h01);
		wr(tmr_pkg::IDX_FLG, 32'h01);
		rc(tmr_pkg::IDX_FLG, 16'h01, 16'h0);
		chk({31'h0, irq}, 0);
		rd(8'hff, d, r);
		chk(d, 0);
		chk({30'h0, r}, {30'h0, tmr_pkg::RESP_SLVERR});
		end_of_test();
	end
endmodule : tmr_regs_bench

bind tmr_regs tmr_chk u_tmr_chk (
	.clk_i    (clk_i),
	.reset_n_i(reset_n_i),
	.axi_req_i(axi_req_i),
	.axi_rsp_o(axi_rsp_o),
	.irq_o    (irq_o)
);
`default_nettype wire
